// [hdl/i2cst_pkg.sv]
package i2cst_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_OWN = 3'h2;
  localparam logic [2:0] ADDR_CTRL = 3'h3;
  localparam logic [2:0] ADDR_SLEEP = 3'h4;
  // control register fields
  localparam int CTRL_INT = 7;
  localparam int CTRL_ACK = 6;
  localparam int CTRL_STA = 5;
  localparam int CTRL_STO = 4;
  localparam int CTRL_WC = 3;
  localparam int CTRL_EN = 2;
  localparam int CTRL_IE = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h75;
  localparam logic [7:0] OWN_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [7:0] GC_ADDR = 8'h00;
  // status codes, prescaler bits zero
  localparam logic [7:0] ST_OWN_READ = 8'ha8;
  localparam logic [7:0] ST_ARB_READ = 8'hb0;
  localparam logic [7:0] ST_DATA_ACK = 8'hb8;
  localparam logic [7:0] ST_DATA_NACK = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK = 8'hc8;
  localparam logic [7:0] ST_NONE = 8'hf8;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam int BIT_LAST = 7;
  typedef enum logic [5:0] {
    I2CST_IDLE = 6'h01,
    I2CST_ADDR = 6'h02,
    I2CST_AACK = 6'h04,
    I2CST_WAIT = 6'h08,
    I2CST_SEND = 6'h10,
    I2CST_MACK = 6'h20
  } i2cst_state_t;
endpackage

// [hdl/i2cst_top.sv]
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
// Operation
// - answer only when received address matches own upper seven bits or enabled general call
// - own address bit zero set enables answering general call address 00
// - wait for own address plus direction bit; read selects transmitter operation
// - after address acknowledged, set interrupt flag and post valid status
// - status codes assume prescaler bits zero; software masks them
// - status a8 after own address with read bit acknowledged
// - status b0 when lost arbitration then own read address acknowledged
// - status b8 after data byte sent and master acknowledged
// - flag cleared with ack enable zero: byte goes out as last, expect nack
// - flag cleared with ack enable one: byte goes out, expect ack
// - after final byte report c0 on nack or c8 on ack
// - after final byte drop to not addressed, further reads see all ones
// - c8 when master acknowledges the byte meant as last
// - ack enable zero: own address not acknowledged, bus still monitored
// - asleep with ack enable set, still match address and raise wake request
// - after wake-up match hold scl low until flag cleared by writing one
// - data register content not guaranteed after waking from sleep
// - in c0 or c8, clearing flag returns to not addressed slave
module i2cst_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic arb_lost_i,
  output logic wake_o
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic [7:0] own_slave_address;
  logic [7:0] serial_control;
  logic [7:0] serial_data_register;
  logic [7:0] serial_status_register;
  logic sleep_mode;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic last_byte;
  logic final_sent;
  logic woke;
  logic sda_drive;
  logic scl_hold;
  i2cst_pkg::i2cst_state_t state;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_match;
  logic gc_hit;
  logic ack_pend;
  logic flag_clear;
  logic flag_set;
  logic [7:0] next_status;

  // two-stage sync, first stage read only by second
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_sync <= 2'h3;
      scl_d <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_sync <= {scl_sync[0], scl_i};
      scl_d <= scl_sync[1];
    end
  end

  // same depth as clock path so start and stop see aligned lines
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sda_sync <= 2'h3;
      sda_d <= 1'b1;
    end
    else if (ce_i)
    begin
      sda_sync <= {sda_sync[0], sda_i};
      sda_d <= sda_sync[1];
    end
  end

  assign scl_rise = scl_sync[1] & ~scl_d;
  assign scl_fall = ~scl_sync[1] & scl_d;
  assign start_cond = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_cond = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  assign flag_clear = wr_i && addr_i == i2cst_pkg::ADDR_CTRL && wdata_i[i2cst_pkg::CTRL_INT];

  // match on upper seven bits, general call only if own bit 0 set
  assign gc_hit = ({shreg[7:1], 1'b0} == i2cst_pkg::GC_ADDR) && own_slave_address[0];
  assign addr_match = (shreg[7:1] == own_slave_address[7:1]) || gc_hit;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      own_slave_address <= i2cst_pkg::OWN_RESET;
    else if (ce_i && wr_i && addr_i == i2cst_pkg::ADDR_OWN)
      own_slave_address <= wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sleep_mode <= 1'b0;
    else if (ce_i && wr_i && addr_i == i2cst_pkg::ADDR_SLEEP)
      sleep_mode <= wdata_i[0];
  end

  // data register; write while flag low counts as collision
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      serial_data_register <= i2cst_pkg::DATA_RESET;
    else if (ce_i && wr_i && addr_i == i2cst_pkg::ADDR_DATA && serial_control[i2cst_pkg::CTRL_INT])
      serial_data_register <= wdata_i;
  end

  // control register; hardware set of the flag wins over software clear
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      serial_control <= i2cst_pkg::CTRL_RESET;
    else if (ce_i)
    begin
      if (wr_i && addr_i == i2cst_pkg::ADDR_CTRL)
      begin
        serial_control <= (serial_control & ~i2cst_pkg::CTRL_WMASK) | (wdata_i & i2cst_pkg::CTRL_WMASK);
        serial_control[i2cst_pkg::CTRL_WC] <= 1'b0;
        if (flag_clear)
          serial_control[i2cst_pkg::CTRL_INT] <= 1'b0;
      end
      if (wr_i && addr_i == i2cst_pkg::ADDR_DATA && !serial_control[i2cst_pkg::CTRL_INT])
        serial_control[i2cst_pkg::CTRL_WC] <= 1'b1;
      if (flag_set)
        serial_control[i2cst_pkg::CTRL_INT] <= 1'b1;
    end
  end

  // bus state machine, on the system clock; sleep only decides whether an address match raises the wake request
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= i2cst_pkg::I2CST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      last_byte <= 1'b0;
      final_sent <= 1'b0;
      sda_drive <= 1'b0;
      flag_set <= 1'b0;
      next_status <= i2cst_pkg::ST_NONE;
      woke <= 1'b0;
      ack_pend <= 1'b0;
    end
    else if (ce_i)
    begin
      flag_set <= 1'b0;
      if (flag_clear)
        woke <= 1'b0;
      if (!serial_control[i2cst_pkg::CTRL_EN])
      begin
        state <= i2cst_pkg::I2CST_IDLE;
        sda_drive <= 1'b0;
        ack_pend <= 1'b0;
      end
      else if (stop_cond || start_cond)
      begin
        state <= start_cond ? i2cst_pkg::I2CST_ADDR : i2cst_pkg::I2CST_IDLE;
        bitcnt <= 3'h0;
        sda_drive <= 1'b0;
        ack_pend <= 1'b0;
      end
      else
      begin
        case (state)
          i2cst_pkg::I2CST_IDLE:
            sda_drive <= 1'b0; // released line reads as ones
          i2cst_pkg::I2CST_ADDR:
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], sda_sync[1]};
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'(i2cst_pkg::BIT_LAST))
                state <= i2cst_pkg::I2CST_AACK;
            end
          i2cst_pkg::I2CST_AACK:
            if (scl_fall)
            begin
              // read bit selects transmitter; write address is not acknowledged, back to idle
              if (addr_match && shreg[0] && serial_control[i2cst_pkg::CTRL_ACK])
              begin
                sda_drive <= 1'b1;
                state <= i2cst_pkg::I2CST_WAIT;
                ack_pend <= 1'b1;
                next_status <= arb_lost_i ? i2cst_pkg::ST_ARB_READ : i2cst_pkg::ST_OWN_READ;
              end
              else
                state <= i2cst_pkg::I2CST_IDLE;
            end
          i2cst_pkg::I2CST_WAIT:
            // flag waits for the end of the ack clock, else the master could not clock the ack in
            if (ack_pend)
            begin
              if (scl_fall)
              begin
                ack_pend <= 1'b0;
                flag_set <= 1'b1;
                woke <= sleep_mode;
              end
            end
            // flag is still high in the cycle of the clearing write
            else if (flag_clear && !flag_set)
            begin
              if (final_sent)
              begin
                final_sent <= 1'b0;
                sda_drive <= 1'b0;
                state <= i2cst_pkg::I2CST_IDLE;
              end
              else
              begin
                last_byte <= ~wdata_i[i2cst_pkg::CTRL_ACK];
                shreg <= serial_data_register;
                sda_drive <= ~serial_data_register[7];
                bitcnt <= 3'h0;
                state <= i2cst_pkg::I2CST_SEND;
              end
            end
          i2cst_pkg::I2CST_SEND:
            if (scl_fall)
            begin
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'(i2cst_pkg::BIT_LAST))
              begin
                sda_drive <= 1'b0;
                state <= i2cst_pkg::I2CST_MACK;
              end
              else
              begin
                shreg <= {shreg[6:0], 1'b1};
                sda_drive <= ~shreg[6];
              end
            end
          i2cst_pkg::I2CST_MACK:
            if (scl_rise)
            begin
              if (last_byte)
              begin
                next_status <= sda_sync[1] ? i2cst_pkg::ST_DATA_NACK : i2cst_pkg::ST_LAST_ACK;
                flag_set <= 1'b1;
                final_sent <= 1'b1;
                state <= i2cst_pkg::I2CST_WAIT;
              end
              else if (!sda_sync[1])
              begin
                next_status <= i2cst_pkg::ST_DATA_ACK;
                flag_set <= 1'b1;
                state <= i2cst_pkg::I2CST_WAIT;
              end
              else
              begin
                next_status <= i2cst_pkg::ST_DATA_NACK;
                flag_set <= 1'b1;
                final_sent <= 1'b1;
                state <= i2cst_pkg::I2CST_WAIT;
              end
            end
          default:
            state <= i2cst_pkg::I2CST_IDLE;
        endcase
      end
    end
  end

  // status reads f8 while flag low; prescaler bits kept zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      serial_status_register <= i2cst_pkg::ST_NONE;
    else if (ce_i)
      serial_status_register <= serial_control[i2cst_pkg::CTRL_INT] ?
        {next_status[7:3], i2cst_pkg::PRESC_RESET} : i2cst_pkg::ST_NONE;
  end

  // clock stretch while flag set, and across wake-up
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      scl_hold <= 1'b0;
    else if (ce_i)
      scl_hold <= (state == i2cst_pkg::I2CST_WAIT && !scl_sync[1]) &&
                  (serial_control[i2cst_pkg::CTRL_INT] || flag_set || woke);
  end

  // open drain: only the enable ever moves
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      scl_o <= 1'b0;
      scl_oe_o <= scl_hold;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sda_o <= 1'b0;
      sda_oe_o <= sda_drive;
    end
  end

  // long wake-up keeps the clock stretched and can block the bus
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      wake_o <= 1'b0;
    else if (ce_i)
      wake_o <= woke;
  end

  // data register may hold stale content after wake; no bus copy kept
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else if (ce_i)
    begin
      if (rd_i)
      begin
        case (addr_i)
          i2cst_pkg::ADDR_DATA: rdata_o <= serial_data_register;
          i2cst_pkg::ADDR_STATUS: rdata_o <= serial_status_register;
          i2cst_pkg::ADDR_OWN: rdata_o <= own_slave_address;
          i2cst_pkg::ADDR_CTRL: rdata_o <= serial_control;
          i2cst_pkg::ADDR_SLEEP: rdata_o <= {7'h00, sleep_mode};
          default: rdata_o <= 8'h00;
        endcase
      end
      else
        rdata_o <= 8'h00;
    end
  end
endmodule

// [verif/i2cst_properties.sv]
`timescale 1ns/100ps
module i2cst_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic arb_lost_i,
  input wire logic wake_o
);
  // flag-clear writes of the last three cycles; release may lag the write
  logic [2:0] clr_d;
  always_ff @(posedge clk_i)
  begin
    clr_d <= {clr_d[1:0], wr_i && addr_i == i2cst_pkg::ADDR_CTRL && wdata_i[i2cst_pkg::CTRL_INT]};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_stat_rd;
    rd_i && addr_i == i2cst_pkg::ADDR_STATUS;
  endsequence
  property p_stat_low;
    s_stat_rd |=> rdata_o[2:0] == 3'h0;
  endproperty
  a_stat_low: assert property (p_stat_low) else $error("status low bits set");
  property p_stat_code;
    s_stat_rd |=> rdata_o inside {8'hf8, 8'ha8, 8'hb0, 8'hb8, 8'hc0, 8'hc8};
  endproperty
  a_stat_code: assert property (p_stat_code) else $error("unknown status code");
  property p_quiet;
    ce_i && !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside read slot");
  property p_release;
    $fell(scl_oe_o) |-> clr_d != 3'h0;
  endproperty
  a_release: assert property (p_release) else $error("clock released without flag clear");
  property p_wake_rise;
    $rose(wake_o) |-> ##[0:4] sda_oe_o;
  endproperty
  a_wake_rise: assert property (p_wake_rise) else $error("wake without address ack");
  property p_wake_clr;
    $fell(wake_o) |-> clr_d != 3'h0;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake dropped without flag clear");
  property p_sda_edge;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("data line moved while clock high");
  property p_open_drain;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
endmodule

// [verif/i2cst_master.sv]
`timescale 1ns/100ps
module i2cst_master (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  // open drain only: a released line is pulled high, never held
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // bounded wait, the slave may stretch the clock
  task automatic rise;
    scl_low_o = 1'b0;
    for (int i = 0; i < 4000 && scl_i !== 1'b1; i++)
      #25;
  endtask
  task automatic start;
    sda_low_o = 1'b1;
    #100 scl_low_o = 1'b1;
  endtask
  task automatic stop;
    #25 sda_low_o = 1'b1;
    #100 rise();
    #75 sda_low_o = 1'b0;
    #100;
  endtask
  task automatic put_bit(input logic b);
    #25 sda_low_o = !b;
    #100 rise();
    #75 scl_low_o = 1'b1;
  endtask
  task automatic get_bit(output logic b);
    #25 sda_low_o = 1'b0;
    #100 rise();
    #50 b = sda_i;
    #25 scl_low_o = 1'b1;
  endtask
  task automatic put_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
  endtask
  task automatic get_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
  endtask
endmodule

// [verif/i2cst_tb_top.sv]
`timescale 1ns/100ps
module i2cst_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic arb = 1'b0;
  logic [7:0] rdata;
  logic scl_oe, sda_oe, m_scl, m_sda, wake;
  wire scl, sda;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  // pull-ups on both lines
  assign scl = ~(m_scl | scl_oe);
  assign sda = ~(m_sda | sda_oe);
  i2cst_top uut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe_o(scl_oe), .sda_o(),
    .sda_oe_o(sda_oe), .arb_lost_i(arb), .wake_o(wake));
  i2cst_master m (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(a, v);
    chk(what, v, exp);
  endtask
  // status lags the flag, so poll with a bound
  task wait_stat(input logic [7:0] exp);
    logic [7:0] v;
    v = i2cst_pkg::ST_NONE;
    for (int i = 0; i < 100 && v === i2cst_pkg::ST_NONE; i++)
      rd_reg(i2cst_pkg::ADDR_STATUS, v);
    chk("status", v, exp);
  endtask
  task addr_phase(input logic [7:0] a, input logic ack);
    logic b;
    m.start();
    m.put_byte(a);
    m.get_bit(b);
    chk("address ack", {7'h00, b}, {7'h00, !ack});
  endtask
  task t_regs;
    rchk("data", i2cst_pkg::ADDR_DATA, i2cst_pkg::DATA_RESET);
    rchk("status", i2cst_pkg::ADDR_STATUS, i2cst_pkg::ST_NONE);
    rchk("own", i2cst_pkg::ADDR_OWN, i2cst_pkg::OWN_RESET);
    rchk("ctrl", i2cst_pkg::ADDR_CTRL, i2cst_pkg::CTRL_RESET);
    rchk("unmapped", 3'h5, 8'h00);
    wr_reg(i2cst_pkg::ADDR_OWN, 8'h54);
    rchk("own", i2cst_pkg::ADDR_OWN, 8'h54);
    wr_reg(i2cst_pkg::ADDR_DATA, 8'h11);
    rchk("collision", i2cst_pkg::ADDR_CTRL, 8'h08);
    rchk("data", i2cst_pkg::ADDR_DATA, 8'hff);
    wr_reg(i2cst_pkg::ADDR_CTRL, 8'h44);
    rchk("ctrl", i2cst_pkg::ADDR_CTRL, 8'h44);
  endtask
  task t_nack;
    wr_reg(i2cst_pkg::ADDR_CTRL, 8'h04);
    addr_phase(8'h55, 1'b0);
    m.stop();
    wr_reg(i2cst_pkg::ADDR_CTRL, 8'h40);
    addr_phase(8'h55, 1'b0);
    m.stop();
    wr_reg(i2cst_pkg::ADDR_CTRL, 8'h44);
    addr_phase(8'h57, 1'b0);
    m.stop();
    addr_phase(8'h01, 1'b0);
    m.stop();
    rchk("status", i2cst_pkg::ADDR_STATUS, i2cst_pkg::ST_NONE);
  endtask
  task t_read(input logic lost, input logic sleep, input logic last_ack);
    logic [7:0] d;
    wr_reg(i2cst_pkg::ADDR_SLEEP, {7'h00, sleep});
    arb <= lost;
    addr_phase(8'h55, 1'b1);
    wait_stat(lost ? i2cst_pkg::ST_ARB_READ : i2cst_pkg::ST_OWN_READ);
    chk("clock hold", {7'h00, scl_oe}, 8'h01);
    chk("wake", {7'h00, wake}, {7'h00, sleep});
    wr_reg(i2cst_pkg::ADDR_SLEEP, 8'h00);
    arb <= 1'b0;
    wr_reg(i2cst_pkg::ADDR_DATA, 8'h96);
    wr_reg(i2cst_pkg::ADDR_CTRL, 8'hc4);
    m.get_byte(d);
    chk("byte", d, 8'h96);
    chk("wake", {7'h00, wake}, 8'h00);
    m.put_bit(1'b0);
    wait_stat(i2cst_pkg::ST_DATA_ACK);
    wr_reg(i2cst_pkg::ADDR_DATA, 8'h5a);
    wr_reg(i2cst_pkg::ADDR_CTRL, 8'h84);
    m.get_byte(d);
    chk("last byte", d, 8'h5a);
    m.put_bit(!last_ack);
    wait_stat(last_ack ? i2cst_pkg::ST_LAST_ACK : i2cst_pkg::ST_DATA_NACK);
    wr_reg(i2cst_pkg::ADDR_CTRL, 8'hc4);
    if (last_ack)
    begin
      m.get_byte(d);
      chk("after last", d, 8'hff);
      m.put_bit(1'b1);
    end
    m.stop();
    rchk("status", i2cst_pkg::ADDR_STATUS, i2cst_pkg::ST_NONE);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_nack();
    t_read(1'b0, 1'b0, 1'b1);
    t_read(1'b1, 1'b1, 1'b0);
    conclude();
  end
endmodule
bind i2cst_top i2cst_properties chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i), .sda_i(sda_i),
  .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .arb_lost_i(arb_lost_i),
  .wake_o(wake_o));
